/* hrxal_pkg.sv */
// shared constants for the receive address match and length check block
package hrxal_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [11:0] HRXAL_OFS_CONTROL      = 12'h130;
  localparam logic [11:0] HRXAL_OFS_STATUS       = 12'h134;
  localparam logic [11:0] HRXAL_OFS_ADDRESS      = 12'h138;
  localparam logic [11:0] HRXAL_OFS_ADDRESS_MASK = 12'h13c;
  localparam logic [11:0] HRXAL_OFS_LENGTH_CHECK = 12'h140;

  // ==========================================================================
  // reset values
  localparam logic [31:0] HRXAL_RST_CONTROL      = 32'h0000_0000;
  localparam logic [31:0] HRXAL_RST_ADDRESS      = 32'h0000_0000;
  localparam logic [31:0] HRXAL_RST_ADDRESS_MASK = 32'h0000_0000;
  localparam logic [31:0] HRXAL_RST_LENGTH_CHECK = 32'h0000_0000;

  // ==========================================================================
  // field positions
  localparam int HRXAL_CTL_HDLC_MODE = 0;
  localparam int HRXAL_CTL_AUTOMODE  = 1;
  localparam int HRXAL_CTL_ADDR16    = 2;
  localparam int HRXAL_CTL_LENGTH_EXCEEDED_IRQ_EN   = 3;
  localparam int HRXAL_ADR_A1H_LSB   = 24;
  localparam int HRXAL_ADR_A1L_LSB   = 16;
  localparam int HRXAL_ADR_A2H_LSB   = 8;
  localparam int HRXAL_ADR_A2L_LSB   = 0;
  localparam int HRXAL_MSK_A2H_LSB   = 24;
  localparam int HRXAL_MSK_A2L_LSB   = 16;
  localparam int HRXAL_MSK_A1H_LSB   = 8;
  localparam int HRXAL_MSK_A1L_LSB   = 0;
  localparam int HRXAL_LEN_ON_BIT    = 15;
  localparam int HRXAL_LEN_CODE_W    = 11;
  localparam int HRXAL_CRI_BIT       = 1;
  localparam int HRXAL_STA_MATCH_BIT = 31;
  localparam int HRXAL_STA_RESP_BIT  = 30;
  localparam int HRXAL_STA_LENGTH_EXCEEDED_IRQ_BIT  = 29;
  localparam logic [31:0] HRXAL_LEN_RW_MASK = 32'h0000_87ff;
  localparam logic [4:0]  HRXAL_LEN_UNIT_SH = 5'h05;
  localparam int HRXAL_CNT_W         = 17;

endpackage : hrxal_pkg

/* hrxal_stream_if.sv */
// valid/ready byte stream between the checker and its output buffer
interface hrxal_stream_if #(
  parameter int W = 11
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : hrxal_stream_if

/* hrxal_skid_buf.sv */
// two-entry skid buffer, output taken straight from the main register
module hrxal_skid_buf #(
  parameter int W = 11
) (
  // clock and reset
  input  wire logic     pclk,
  input  wire logic     presetn,
  // streams
  hrxal_stream_if.sink   s_in,
  hrxal_stream_if.source s_out
);

  logic         main_vld_q;
  logic [W-1:0] main_dat_q;
  logic         skid_vld_q;
  logic [W-1:0] skid_dat_q;
  logic         in_fire;
  logic         out_fire;

  assign in_fire     = s_in.valid & ~skid_vld_q;
  assign out_fire    = main_vld_q & s_out.ready;
  assign s_in.ready  = ~skid_vld_q;
  assign s_out.valid = main_vld_q;
  assign s_out.data  = main_dat_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_vld_q <= 1'b0;
      main_dat_q <= '0;
    end else if (!main_vld_q || out_fire) begin
      main_vld_q <= skid_vld_q | in_fire;
      main_dat_q <= skid_vld_q ? skid_dat_q : s_in.data;
    end
  end

  // second entry catches a word while the drain side stalls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skid_vld_q <= 1'b0;
      skid_dat_q <= '0;
    end else if (skid_vld_q) begin
      if (out_fire) begin
        skid_vld_q <= 1'b0;
      end
    end else if (in_fire && main_vld_q && !out_fire) begin
      skid_vld_q <= 1'b1;
      skid_dat_q <= s_in.data;
    end
  end

endmodule : hrxal_skid_buf

/* hrxal_top.sv */
// receive address match and frame length check with apb registers
// Functional notes
// R1 - mask bit one: that address bit always compares equal
// R2 - mask bit zero: received address bit must equal the programmed bit
// R3 - mask word: addr2 high 31:24, addr2 low 23:16, addr1 high 15:8, addr1 low 7:0
// R4 - 16-bit address: addr1 low byte is the first individual low byte
// R5 - 8-bit address: addr1 low byte identifies a command frame
// R6 - 8-bit address: addr2 low byte identifies a response frame
// R7 - second high/low address pair compared alongside the first
// R8 - length check off: no length checking at all
// R9 - length check on (bit 15): count every forwarded byte against limit
// R10 - over-length frame handled as line abort, abort pulse and status
// R11 - over-length also raises length-exceeded pulse when enabled
// R12 - final status byte counts toward the frame length
// R13 - limit is (11-bit code plus one) times 32 bytes
// R14 - length check only acts in hdlc mode
// R15 - received high and low address bytes compared under the mask
// R16 - automode: cr polarity bit flips meaning of received c/r bit; code does this in 16-bit mode only, 8-bit mode uses addr2 low match
// R17 - software keeps addr1 high byte zero for 8-bit automode
// R18 - unused length bits read zero, all fields reset to zero
//
// The implementer's own choice: the APB slave port.
module hrxal_top
  import hrxal_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // received bytes, last one is the frame status byte
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_data,
  input  wire logic        in_last,
  output logic             in_ready,
  // bytes toward the receive fifo
  output logic             out_valid,
  output logic [7:0]       out_data,
  output logic             out_last,
  output logic             out_addr_match,
  output logic             out_is_response,
  input  wire logic        out_ready,
  // events
  output logic             receive_abort_irq,
  output logic             length_exceeded_irq
);
  localparam int BW = 11;

  // ==========================================================================
  // registers
  logic [31:0] control_q;
  logic [31:0] receive_address_bytes_q;
  logic [31:0] address_mask_q;
  logic [31:0] length_check_q;
  logic        length_exceeded_irq_sticky_q;
  logic        last_match_q;
  logic        last_resp_q;
  logic [HRXAL_CNT_W-1:0] count_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  logic        hdlc_mode;
  logic        automode;
  logic        addr16;
  logic        length_exceeded_irq_en;
  logic [7:0]  addr1_low_byte;
  logic [7:0]  addr1_high_byte;
  logic [7:0]  addr2_low_byte;
  logic [7:0]  addr2_high_byte;
  logic [7:0]  mask_addr1_low;
  logic [7:0]  mask_addr1_high;
  logic [7:0]  mask_addr2_low;
  logic [7:0]  mask_addr2_high;
  logic [7:0]  mask_hi1_eff;
  logic        length_check_on;
  logic [HRXAL_LEN_CODE_W-1:0] length_limit_code;

  assign hdlc_mode         = control_q[HRXAL_CTL_HDLC_MODE];
  assign automode          = control_q[HRXAL_CTL_AUTOMODE];
  assign addr16            = control_q[HRXAL_CTL_ADDR16];
  assign length_exceeded_irq_en           = control_q[HRXAL_CTL_LENGTH_EXCEEDED_IRQ_EN];
  assign addr1_high_byte   = receive_address_bytes_q[HRXAL_ADR_A1H_LSB +: 8];
  assign addr1_low_byte    = receive_address_bytes_q[HRXAL_ADR_A1L_LSB +: 8];
  assign addr2_high_byte   = receive_address_bytes_q[HRXAL_ADR_A2H_LSB +: 8];
  assign addr2_low_byte    = receive_address_bytes_q[HRXAL_ADR_A2L_LSB +: 8];
  assign mask_addr2_high   = address_mask_q[HRXAL_MSK_A2H_LSB +: 8]; // R3
  assign mask_addr2_low    = address_mask_q[HRXAL_MSK_A2L_LSB +: 8]; // R3
  assign mask_addr1_high   = address_mask_q[HRXAL_MSK_A1H_LSB +: 8]; // R3
  assign mask_addr1_low    = address_mask_q[HRXAL_MSK_A1L_LSB +: 8]; // R3
  assign length_check_on   = length_check_q[HRXAL_LEN_ON_BIT];
  assign length_limit_code = length_check_q[HRXAL_LEN_CODE_W-1:0];

  // ==========================================================================
  // apb slave, one wait state per transfer
  logic        apb_done;
  logic        apb_wr;
  logic        apb_mapped;
  logic [31:0] rd_word;

  assign apb_done = psel & penable & pready_q;
  assign apb_wr   = apb_done & pwrite & ~pslverr_q;

  always_comb begin
    apb_mapped = 1'b1;
    rd_word    = 32'h0000_0000;
    unique case (paddr)
      HRXAL_OFS_CONTROL:      rd_word = control_q;
      HRXAL_OFS_STATUS: begin
        rd_word[HRXAL_STA_MATCH_BIT]   = last_match_q;
        rd_word[HRXAL_STA_RESP_BIT]    = last_resp_q;
        rd_word[HRXAL_STA_LENGTH_EXCEEDED_IRQ_BIT]    = length_exceeded_irq_sticky_q;
        rd_word[HRXAL_CNT_W-1:0]       = count_q;
      end
      HRXAL_OFS_ADDRESS:      rd_word = receive_address_bytes_q;
      HRXAL_OFS_ADDRESS_MASK: rd_word = address_mask_q;
      HRXAL_OFS_LENGTH_CHECK: rd_word = length_check_q;
      default:                apb_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~apb_mapped;
      if (psel && penable && !pready_q && !pwrite) begin
        prdata_q <= rd_word;
      end else if (apb_done) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q               <= HRXAL_RST_CONTROL; // R18
      receive_address_bytes_q <= HRXAL_RST_ADDRESS; // R18
      address_mask_q          <= HRXAL_RST_ADDRESS_MASK; // R18
      length_check_q          <= HRXAL_RST_LENGTH_CHECK; // R18
    end else if (apb_wr) begin
      unique case (paddr)
        HRXAL_OFS_CONTROL:      control_q <= pwdata & 32'h0000_000f;
        HRXAL_OFS_ADDRESS:      receive_address_bytes_q <= pwdata;
        HRXAL_OFS_ADDRESS_MASK: address_mask_q <= pwdata; // R3
        HRXAL_OFS_LENGTH_CHECK: length_check_q <= pwdata & HRXAL_LEN_RW_MASK; // R18
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // address comparison
  function automatic logic byte_eq(input logic [7:0] rx, input logic [7:0] prog, input logic [7:0] msk);
    byte_eq = &(~(rx ^ prog) | msk); // R1 R2
  endfunction : byte_eq
  logic       in_fire;
  logic [1:0] byte_idx_q;
  logic [7:0] hi_byte_q;
  logic       match_q;
  logic       resp_q;
  logic       addr_now;
  logic       match_now;
  logic       resp_now;
  logic       cr_bit;
  logic       m1;
  logic       m2;

  // c/r position in automode is not an address bit in the addr1 high byte compare
  always_comb begin
    mask_hi1_eff = mask_addr1_high;
    if (automode) begin
      mask_hi1_eff[HRXAL_CRI_BIT] = 1'b1;
    end
  end

  assign cr_bit = hi_byte_q[HRXAL_CRI_BIT];

  always_comb begin
    addr_now  = 1'b0;
    m1        = 1'b0;
    m2        = 1'b0;
    match_now = match_q;
    resp_now  = resp_q;
    if (!hdlc_mode) begin
      match_now = 1'b1;
      resp_now  = 1'b0;
    end else if (addr16) begin
      addr_now = (byte_idx_q == 2'd1);
      m1 = byte_eq(hi_byte_q, addr1_high_byte, mask_hi1_eff)
         & byte_eq(in_data, addr1_low_byte, mask_addr1_low); // R4 R15
      m2 = byte_eq(hi_byte_q, addr2_high_byte, mask_addr2_high)
         & byte_eq(in_data, addr2_low_byte, mask_addr2_low); // R7
      if (addr_now) begin
        match_now = m1 | m2;
        resp_now  = automode ? (addr1_high_byte[HRXAL_CRI_BIT] ? cr_bit : ~cr_bit) : m2 & ~m1; // R16
      end
    end else begin
      addr_now = (byte_idx_q == 2'd0);
      m1 = byte_eq(in_data, addr1_low_byte, mask_addr1_low); // R5
      m2 = byte_eq(in_data, addr2_low_byte, mask_addr2_low); // R6 R7
      if (addr_now) begin
        match_now = m1 | m2;
        resp_now  = m2 & ~m1;
      end
    end
  end

  // ==========================================================================
  // length check
  logic                   checking;
  logic [HRXAL_CNT_W-1:0] limit;
  logic [HRXAL_CNT_W-1:0] count_inc;
  logic                   over;
  logic                   discard_q;
  logic                   forward;

  assign checking  = hdlc_mode & length_check_on; // R8 R14
  assign limit     = HRXAL_CNT_W'({6'h00, length_limit_code} + 17'h00001) << HRXAL_LEN_UNIT_SH; // R13
  assign count_inc = count_q + 17'h00001; // R12
  assign over      = checking & (count_inc > limit); // R9
  assign forward   = in_fire & ~discard_q & ~over;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_idx_q <= 2'd0;
      hi_byte_q  <= 8'h00;
    end else if (in_fire) begin
      if (in_last) begin
        byte_idx_q <= 2'd0;
      end else if (byte_idx_q != 2'd3) begin
        byte_idx_q <= byte_idx_q + 2'd1;
      end
      if (byte_idx_q == 2'd0) begin
        hi_byte_q <= in_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_q <= 1'b0;
      resp_q  <= 1'b0;
    end else if (in_fire && addr_now) begin
      match_q <= match_now;
      resp_q  <= resp_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (in_fire) begin
      if (in_last) begin
        count_q <= '0;
      end else if (forward) begin
        count_q <= count_inc; // R9 R12
      end
    end
  end

  // rest of an over-length frame is swallowed up to its last byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discard_q <= 1'b0;
    end else if (in_fire) begin
      if (in_last) begin
        discard_q <= 1'b0;
      end else if (over) begin
        discard_q <= 1'b1; // R10
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_abort_irq   <= 1'b0;
      length_exceeded_irq <= 1'b0;
    end else begin
      receive_abort_irq   <= in_fire & ~discard_q & over; // R10
      length_exceeded_irq <= in_fire & ~discard_q & over & length_exceeded_irq_en; // R11
    end
  end

  // sticky status, a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      length_exceeded_irq_sticky_q <= 1'b0;
    end else if (in_fire && !discard_q && over) begin
      length_exceeded_irq_sticky_q <= 1'b1; // R10
    end else if (apb_wr && paddr == HRXAL_OFS_STATUS && pwdata[HRXAL_STA_LENGTH_EXCEEDED_IRQ_BIT]) begin
      length_exceeded_irq_sticky_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_match_q <= 1'b0;
      last_resp_q  <= 1'b0;
    end else if (forward && in_last) begin
      last_match_q <= match_now;
      last_resp_q  <= resp_now;
    end
  end

  // ==========================================================================
  // output buffer
  hrxal_stream_if #(.W(BW)) buf_in ();
  hrxal_stream_if #(.W(BW)) buf_out ();

  assign in_fire       = in_valid & buf_in.ready;
  assign buf_in.valid  = forward;
  assign buf_in.data   = {match_now & in_last, resp_now & in_last, in_last, in_data};
  assign buf_out.ready = out_ready;

  hrxal_skid_buf #(.W(BW)) u_buf (
    .pclk    (pclk),
    .presetn (presetn),
    .s_in    (buf_in),
    .s_out   (buf_out)
  );

  assign in_ready        = buf_in.ready;
  assign out_valid       = buf_out.valid;
  assign out_addr_match  = buf_out.data[10];
  assign out_is_response = buf_out.data[9];
  assign out_last        = buf_out.data[8];
  assign out_data        = buf_out.data[7:0];

endmodule : hrxal_top

/* hrxal_station.sv */
// remote station model offering received frame bytes to the block
module hrxal_station (
  // clock
  input  wire logic       pclk,
  // byte stream toward the block
  output logic            in_valid,
  output logic [7:0]      in_data,
  output logic            in_last,
  input  wire logic       in_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    in_valid = 1'b0;
    in_data  = 8'h00;
    in_last  = 1'b0;
  end

  // ==========================================================================
  // frame: two address bytes, fill bytes, status byte last
  task automatic send(input int n, input logic [7:0] a0, input logic [7:0] a1, input int gap);
    @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_data  <= (i == 0) ? a0 : (i == 1) ? a1 : 8'(i);
      in_last  <= (i == n - 1);
      do @(posedge pclk); while (in_ready !== 1'b1);
      if (gap > 0 && i < n - 1) begin
        // released line shows no stale byte
        in_valid <= 1'b0;
        in_data  <= ~in_data;
        repeat (gap) @(posedge pclk);
      end
    end
    in_valid <= 1'b0;
    in_last  <= 1'b0;
    in_data  <= ~in_data;
  endtask : send
endmodule : hrxal_station

/* hrxal_top_chk.sv */
// port assertions of the address match and length check block
module hrxal_top_chk
  import hrxal_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  // output stream and events
  input  wire logic        out_valid,
  input  wire logic [7:0]  out_data,
  input  wire logic        out_last,
  input  wire logic        out_addr_match,
  input  wire logic        out_is_response,
  input  wire logic        out_ready,
  input  wire logic        receive_abort_irq,
  input  wire logic        length_exceeded_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_length_exceeded_irq_abort; length_exceeded_irq |-> receive_abort_irq; endproperty
  a_length_exceeded_irq_abort: assert property (p_length_exceeded_irq_abort) else $error("length pulse without abort");
  property p_abort_pulse; receive_abort_irq |=> !receive_abort_irq; endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort pulse too long");
  property p_mid_clear; out_valid && !out_last |-> !out_addr_match && !out_is_response; endproperty
  a_mid_clear: assert property (p_mid_clear) else $error("match flag on inner byte");
  property p_resp_match; out_valid && out_last && out_is_response |-> out_addr_match; endproperty
  a_resp_match: assert property (p_resp_match) else $error("response without match");
  property p_out_hold; out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last); endproperty
  a_out_hold: assert property (p_out_hold) else $error("stalled byte changed");
  property p_wait_one; psel && penable && !pready |=> pready; endproperty
  a_wait_one: assert property (p_wait_one) else $error("apb answer late");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_unmapped;
    pready && !(paddr inside {12'h130, 12'h134, 12'h138, 12'h13c, 12'h140}) |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_len_unused;
    pready && !pwrite && paddr == HRXAL_OFS_LENGTH_CHECK |-> (prdata & 32'hffff_7800) == 32'h0;
  endproperty
  a_len_unused: assert property (p_len_unused) else $error("unused length bits set");
endmodule : hrxal_top_chk

bind hrxal_top hrxal_top_chk hrxal_top_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr), .out_valid(out_valid),
  .out_data(out_data), .out_last(out_last), .out_addr_match(out_addr_match),
  .out_is_response(out_is_response), .out_ready(out_ready), .receive_abort_irq(receive_abort_irq),
  .length_exceeded_irq(length_exceeded_irq)
);

/* tb_top.sv */
// self-checking bench for the address match and length check block
module tb_top
  import hrxal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, in_valid, in_last, in_ready;
  logic [7:0]  in_data, out_data, fa0, fa1, fexp;
  logic        out_valid, out_last, out_addr_match, out_is_response;
  logic        out_ready = 1'b1, stall = 1'b0, last_m, last_r;
  logic        receive_abort_irq, length_exceeded_irq;
  int          miscompares = 0, compares = 0, cyc = 0, fbase = 0;
  int          nbytes = 0, nlast = 0, nab = 0, nfx = 0, d_bytes, d_last, d_ab, d_fx;

  always #2 pclk = ~pclk;

  hrxal_top hrxal_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_addr_match(out_addr_match),
    .out_is_response(out_is_response), .out_ready(out_ready), .receive_abort_irq(receive_abort_irq),
    .length_exceeded_irq(length_exceeded_irq));
  hrxal_station hrxal_station_i (.pclk(pclk), .in_valid(in_valid), .in_data(in_data), .in_last(in_last),
    .in_ready(in_ready));

  // ==========================================================================
  // drain side: stalls three cycles of four when asked
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    out_ready <= !stall || (cyc % 4 == 0);
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      fexp = (nbytes == fbase) ? fa0 : (nbytes == fbase + 1) ? fa1 : 8'(nbytes - fbase);
      chk({24'h0, out_data}, {24'h0, fexp});
      nbytes++;
      if (out_last === 1'b1) begin
        nlast++;
        last_m = out_addr_match;
        last_r = out_is_response;
      end
    end
    if (receive_abort_irq === 1'b1) nab++;
    if (length_exceeded_irq === 1'b1) nfx++;
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(32'h1, 32'h0);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd

  task automatic frame(input int n, input logic [7:0] a0, input logic [7:0] a1, input int gap);
    int b0, l0, ab0, fx0, k;
    b0 = nbytes;
    l0 = nlast;
    ab0 = nab;
    fx0 = nfx;
    k = 0;
    fbase = nbytes;
    fa0 = a0;
    fa1 = a1;
    hrxal_station_i.send(n, a0, a1, gap);
    repeat (3) @(posedge pclk);
    while (out_valid !== 1'b0 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    d_bytes = nbytes - b0;
    d_last = nlast - l0;
    d_ab = nab - ab0;
    d_fx = nfx - fx0;
  endtask : frame

  task automatic lchk(input int n, input int xb, input int xl, input int xa, input int xf);
    frame(n, 8'h12, 8'h34, 0);
    chk(d_bytes, xb);
    chk(d_last, xl);
    chk(d_ab, xa);
    chk(d_fx, xf);
  endtask : lchk

  // ==========================================================================
  // scenarios
  task automatic t_regs;
    rd(HRXAL_OFS_ADDRESS_MASK, 32'h0, 1'b0);
    rd(HRXAL_OFS_LENGTH_CHECK, 32'h0, 1'b0);
    wr(HRXAL_OFS_LENGTH_CHECK, 32'hffff_ffff);
    rd(HRXAL_OFS_LENGTH_CHECK, 32'h0000_87ff, 1'b0);
    wr(HRXAL_OFS_ADDRESS_MASK, 32'h8000_0001);
    rd(HRXAL_OFS_ADDRESS_MASK, 32'h8000_0001, 1'b0);
    rd(12'h200, 32'h0, 1'b1);
  endtask : t_regs

  task automatic t_match16;
    logic [7:0] a0 [6] = '{8'h12, 8'h12, 8'h12, 8'h56, 8'hd6, 8'h56};
    logic [7:0] a1 [6] = '{8'h34, 8'h35, 8'h36, 8'h78, 8'h78, 8'h79};
    logic [1:0] x  [6] = '{2'b10, 2'b10, 2'b00, 2'b11, 2'b11, 2'b00};
    wr(HRXAL_OFS_CONTROL, 32'h0000_0005);
    wr(HRXAL_OFS_ADDRESS, 32'h1234_5678);
    for (int i = 0; i < 6; i++) begin
      frame(4, a0[i], a1[i], i % 2);
      chk({30'h0, last_m, last_r}, {30'h0, x[i]});
    end
  endtask : t_match16

  task automatic t_match8;
    logic [7:0] a0 [4] = '{8'h34, 8'h78, 8'h35, 8'h12};
    logic [1:0] x  [4] = '{2'b10, 2'b11, 2'b10, 2'b00};
    wr(HRXAL_OFS_CONTROL, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      frame(3, a0[i], 8'h00, 0);
      chk({30'h0, last_m, last_r}, {30'h0, x[i]});
    end
  endtask : t_match8

  task automatic t_length;
    wr(HRXAL_OFS_CONTROL, 32'h0000_000d);
    wr(HRXAL_OFS_LENGTH_CHECK, 32'h0000_8000);
    lchk(32, 32, 1, 0, 0);
    lchk(33, 32, 0, 1, 1);
    wr(HRXAL_OFS_CONTROL, 32'h0000_0005);
    lchk(33, 32, 0, 1, 0);
    wr(HRXAL_OFS_LENGTH_CHECK, 32'h0000_8001);
    lchk(64, 64, 1, 0, 0);
    lchk(65, 64, 0, 1, 0);
    rd(HRXAL_OFS_STATUS, 32'ha000_0000, 1'b0);
    wr(HRXAL_OFS_STATUS, 32'h2000_0000);
    rd(HRXAL_OFS_STATUS, 32'h8000_0000, 1'b0);
  endtask : t_length

  task automatic t_nocheck;
    stall <= 1'b1;
    wr(HRXAL_OFS_LENGTH_CHECK, 32'h0000_0001);
    lchk(70, 70, 1, 0, 0);
    wr(HRXAL_OFS_CONTROL, 32'h0000_000c);
    wr(HRXAL_OFS_LENGTH_CHECK, 32'h0000_8000);
    lchk(40, 40, 1, 0, 0);
    chk({30'h0, last_m, last_r}, 32'h2);
    stall <= 1'b0;
  endtask : t_nocheck

  task automatic t_auto;
    logic [7:0] a0 [4] = '{8'h10, 8'h12, 8'h12, 8'h10};
    logic [1:0] x  [4] = '{2'b10, 2'b11, 2'b10, 2'b11};
    wr(HRXAL_OFS_CONTROL, 32'h0000_0007);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        wr(HRXAL_OFS_ADDRESS, 32'h1034_5678);
      end
      frame(4, a0[i], 8'h34, 0);
      chk({30'h0, last_m, last_r}, {30'h0, x[i]});
    end
    wr(HRXAL_OFS_CONTROL, 32'h0000_0003);
    wr(HRXAL_OFS_ADDRESS, 32'h0034_5678);
    frame(3, 8'h78, 8'h00, 0);
    chk({30'h0, last_m, last_r}, 32'h3);
  endtask : t_auto

  // ==========================================================================
  // verdict
  task automatic final_report;
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_match16;
    t_match8;
    t_length;
    t_nocheck;
    t_auto;
    final_report;
  end

  initial begin
    #200000;
    miscompares++;
    final_report;
  end
endmodule : tb_top
